// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import ttw_pkg::*;
();
  logic clk, rst_n, awv, wv, bry, arv, rry, rqv, rqf, err;
  logic [7:0] awa, ara;
  logic [31:0] wd, rqa, base, d, va, a, x;
  logic [3:0] dly;
  wire logic awr, wr, bv, arr, rv, rqr, rsv, su, pab, dab, l2v, l2f, mv, mr, mdv, merr, irq;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd, pa, l2a, l2va, ma, md;
  wire logic [3:0] fs;
  wire ttw_attr_s at;
  int seed = 60852;
  int err_count = 0, checks_done = 0, t;

  // Bench clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ttw_l1_walker i_dut (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .CLK_EN_IN(1'b1),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
    .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr), .S_AXI_BRESP_OUT(br),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rry), .REQ_VALID_IN(rqv), .REQ_VA_IN(rqa), .REQ_IS_FETCH_IN(rqf), .REQ_READY_OUT(rqr),
    .RSP_VALID_OUT(rsv), .RSP_PA_OUT(pa), .RSP_ATTR_OUT(at), .RSP_SUPER_OUT(su), .RSP_PREFETCH_ABORT_OUT(pab),
    .RSP_DATA_ABORT_OUT(dab), .RSP_FAULT_STATUS_OUT(fs), .L2_VALID_OUT(l2v), .L2_ENTRY_ADDR_OUT(l2a),
    .L2_VA_OUT(l2va), .L2_IS_FETCH_OUT(l2f), .MEM_RD_VALID_OUT(mv), .MEM_RD_ADDR_OUT(ma),
    .MEM_RD_READY_IN(mr), .MEM_RD_DATA_VALID_IN(mdv), .MEM_RD_DATA_IN(md), .MEM_RD_ERR_IN(merr), .IRQ_OUT(irq));
  ttw_mem_model i_mem (.clk_in(clk), .arst_n_in(rst_n), .rd_valid_in(mv), .rd_addr_in(ma), .rd_ready_out(mr),
    .data_valid_out(mdv), .data_out(md), .err_out(merr), .dly_in(dly), .err_in(err));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One edge; a wait that overruns ends the run as a mismatch
  task automatic step(inout int n);
    @(posedge clk);
    n++;
    if (n > 300) begin
      err_count++;
      give_verdict();
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Register write; each half released on its own ready
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] ex);
    int n = 0;
    step(n);
    {awa, wd} <= {ad, dt};
    {awv, wv, bry} <= 3'h7;
    do begin
      step(n);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (awv && !awr || wv && !wr);
    while (!bv) step(n);
    bry <= 1'b0;
    chk("bresp", br, ex);
  endtask

  task automatic axr(input logic [7:0] ad, output logic [31:0] dt, input logic [1:0] ex);
    int n = 0;
    step(n);
    ara <= ad;
    {arv, rry} <= 2'h3;
    do step(n); while (!arr);
    arv <= 1'b0;
    do step(n); while (!rv);
    rry <= 1'b0;
    dt = rd;
    chk("rresp", rr, ex);
  endtask

  // Core request held until taken, then await an answer
  task automatic rq(input logic [31:0] v, input logic f);
    int n = 0;
    step(n);
    {rqa, rqf, rqv} <= {v, f, 1'b1};
    do step(n); while (!rqr);
    rqv <= 1'b0;
    do step(n); while (!(rsv || l2v));
  endtask

  initial begin
    {awv, wv, bry, arv, rry, rqv, rqf, err, awa, ara, wd, rqa, dly} = '0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    axr(OFS_CTRL, x, RESP_OKAY);
    chk("ctrl", x, CTRL_RST);
    axr(8'h1c, x, RESP_SLVERR);
    axw(OFS_WALKS, 32'h1, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      va = $random(seed);
      rq(va, i[0]);
      chk("flat_pa", pa, va);
      chk("flat_reads", 32'(i_mem.reads), 32'h0);
    end
    base = $random(seed) & 32'hffffc000;
    axw(OFS_BASE, base, RESP_OKAY);
    axw(OFS_MASK, 32'h1, RESP_OKAY);
    axw(OFS_CTRL, 32'h1, RESP_OKAY);
    // Five descriptor kinds and a read error, fetch and data, random memory pace
    for (int k = 0; k < 12; k++) begin
      for (int f = 0; f < 2; f++) begin
        t = k % 6;
        va = $random(seed);
        d = $random(seed);
        d[1:0] = t == 2 ? DT_FAULT : t == 3 ? 2'h3 : t == 4 ? DT_TABLE : DT_SECTION;
        d[18] = t == 1;
        a = {base[31:14], 14'h0} + {18'h0, va[31:20], 2'h0};
        i_mem.mem[a] = d;
        if (t == 1) for (int j = 0; j < 16; j++) i_mem.mem[{base[31:14], va[31:24], 4'(j), 2'h0}] = d;
        err <= t == 5;
        dly <= 4'($random(seed) & 7);
        rq(va, f[0]);
        chk("fetch_addr", i_mem.last_a, a);
        chk("done_kind", {rsv, l2v}, t == 4 ? 2'h1 : 2'h2);
        if (t == 4) begin
          chk("l2_addr", l2a, {d[31:10], va[19:12], 2'h0});
          chk("l2_va", l2va, va);
          chk("l2_fetch", l2f, f[0]);
        end else begin
          chk("abort", {pab, dab}, t > 1 ? (f ? 2'h2 : 2'h1) : 2'h0);
          chk("fstat", fs, t == 2 ? FS_TRANSLATE : t == 3 ? FS_RESERVED : t == 5 ? FS_EXTERNAL : FS_NONE);
        end
        if (t < 2) begin
          chk("pa", pa, d[18] ? {d[31:24], va[23:0]} : {d[31:20], va[19:0]});
          chk("super", su, d[18]);
          chk("attr", at, {d[17:10], d[8:2]});
        end
      end
    end
    err <= 1'b0;
    axr(OFS_WALKS, x, RESP_OKAY);
    chk("walks", x, 32'h18);
    axr(OFS_STATUS, x, RESP_OKAY);
    chk("status", x, 32'h7);
    chk("irq_on", irq, 1'b1);
    axw(OFS_MASK, 32'h0, RESP_OKAY);
    axr(OFS_MASK, x, RESP_OKAY);
    chk("irq_masked", irq, 1'b0);
    axw(OFS_MASK, 32'h7, RESP_OKAY);
    axw(OFS_STATUS, 32'h7, RESP_OKAY);
    axr(OFS_STATUS, x, RESP_OKAY);
    chk("status_clr", x, 32'h0);
    chk("irq_off", irq, 1'b0);
    give_verdict();
  end
endmodule // testbench

// File: bench/ttw_l1_walker_monitor.sv
`timescale 1ns/1ps
module ttw_l1_walker_monitor
  import ttw_pkg::*;
(
  // Watched ports
  input wire logic        SYS_CLK_IN,
  input wire logic        ARST_N_IN,
  input wire logic        CLK_EN_IN,
  input wire logic        REQ_VALID_IN,
  input wire logic [31:0] REQ_VA_IN,
  input wire logic        REQ_READY_OUT,
  input wire logic        RSP_VALID_OUT,
  input wire logic [31:0] RSP_PA_OUT,
  input wire logic        RSP_PREFETCH_ABORT_OUT,
  input wire logic        RSP_DATA_ABORT_OUT,
  input wire logic [3:0]  RSP_FAULT_STATUS_OUT,
  input wire logic        L2_VALID_OUT,
  input wire logic        MEM_RD_VALID_OUT,
  input wire logic [31:0] MEM_RD_ADDR_OUT,
  input wire logic        MEM_RD_READY_IN,
  input wire logic        MEM_RD_DATA_VALID_IN
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // Request accepted; a frozen clock enable takes nothing
  wire logic take = REQ_VALID_IN && REQ_READY_OUT && CLK_EN_IN;

  // Ready still high after a take means flat path
  a_flat_map: assert property (take ##1 REQ_READY_OUT |-> RSP_VALID_OUT && !MEM_RD_VALID_OUT && RSP_PA_OUT == $past(REQ_VA_IN))
    else $error("flat mapping broken");
  a_walk_reads: assert property (take ##1 !REQ_READY_OUT |-> MEM_RD_VALID_OUT)
    else $error("walk without read");
  a_read_held: assert property (MEM_RD_VALID_OUT && !(MEM_RD_READY_IN && CLK_EN_IN) |=> MEM_RD_VALID_OUT && $stable(MEM_RD_ADDR_OUT))
    else $error("read request dropped");
  a_read_single: assert property (MEM_RD_VALID_OUT && MEM_RD_READY_IN && CLK_EN_IN |=> !MEM_RD_VALID_OUT [*2])
    else $error("extra descriptor read");
  a_word_aligned: assert property (MEM_RD_VALID_OUT |-> MEM_RD_ADDR_OUT[1:0] == 2'h0 && !REQ_READY_OUT)
    else $error("bad read address");
  a_answer_next: assert property (MEM_RD_DATA_VALID_IN && CLK_EN_IN && !MEM_RD_VALID_OUT && !REQ_READY_OUT
    |=> REQ_READY_OUT && (RSP_VALID_OUT != L2_VALID_OUT))
    else $error("no answer after data");
  a_abort_single: assert property (RSP_VALID_OUT |-> !(RSP_PREFETCH_ABORT_OUT && RSP_DATA_ABORT_OUT))
    else $error("both aborts");
  a_abort_cause: assert property (RSP_VALID_OUT |-> (RSP_PREFETCH_ABORT_OUT || RSP_DATA_ABORT_OUT) == (RSP_FAULT_STATUS_OUT != FS_NONE))
    else $error("abort without cause");
  // Main scenarios
  c_flat: cover property (take ##1 REQ_READY_OUT);
  c_l2: cover property (L2_VALID_OUT);
  c_abort: cover property (RSP_VALID_OUT && RSP_PREFETCH_ABORT_OUT);
endmodule // ttw_l1_walker_monitor

bind ttw_l1_walker ttw_l1_walker_monitor i_mon (.*);

// File: bench/ttw_mem_model.sv
`timescale 1ns/1ps
module ttw_mem_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // Descriptor read port
  input  wire logic        rd_valid_in,
  input  wire logic [31:0] rd_addr_in,
  output logic             rd_ready_out,
  output logic             data_valid_out,
  output logic [31:0]      data_out,
  output logic             err_out,
  // Pace and error injection
  input  wire logic [3:0]  dly_in,
  input  wire logic        err_in
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] last_a;
  int          reads = 0;

  // Idle data toggles so a stale word never passes
  initial begin
    rd_ready_out <= 1'b0;
    data_valid_out <= 1'b0;
    data_out <= 32'h0;
    err_out <= 1'b0;
    forever begin
      @(posedge clk_in);
      data_valid_out <= 1'b0;
      err_out <= 1'b0;
      data_out <= ~data_out;
      if (rd_valid_in && arst_n_in) begin
        repeat (dly_in) @(posedge clk_in);
        rd_ready_out <= 1'b1;
        last_a = rd_addr_in;
        @(posedge clk_in);
        rd_ready_out <= 1'b0;
        reads++;
        repeat (dly_in) @(posedge clk_in);
        data_valid_out <= 1'b1;
        data_out <= mem[last_a];
        err_out <= err_in;
      end
    end
  end
endmodule // ttw_mem_model

// File: rtl/ttw_axil_slave.sv
`timescale 1ns/1ps
module ttw_axil_slave
  import ttw_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              ce_in,
  // Write channels
  input  wire logic [REG_AW-1:0] awaddr_in,
  input  wire logic              awvalid_in,
  output logic                   awready_out,
  input  wire logic [31:0]       wdata_in,
  input  wire logic [3:0]        wstrb_in,
  input  wire logic              wvalid_in,
  output logic                   wready_out,
  output logic [1:0]             bresp_out,
  output logic                   bvalid_out,
  input  wire logic              bready_in,
  // Read channels
  input  wire logic [REG_AW-1:0] araddr_in,
  input  wire logic              arvalid_in,
  output logic                   arready_out,
  output logic [31:0]            rdata_out,
  output logic [1:0]             rresp_out,
  output logic                   rvalid_out,
  input  wire logic              rready_in,
  // Register side
  ttw_reg_if.bus                 rif
);

  logic              aw_got_r;
  logic              w_got_r;
  logic [REG_AW-1:0] addr_r;
  logic [31:0]       data_r;
  logic [3:0]        strb_r;

  wire logic aw_hs = awvalid_in && awready_out;
  wire logic w_hs  = wvalid_in && wready_out;

  // Write fires once both halves are held, either order
  assign rif.wr_en   = aw_got_r && w_got_r && !bvalid_out;
  assign rif.wr_addr = addr_r;
  assign rif.wr_data = data_r;
  assign rif.wr_strb = strb_r;
  assign rif.rd_en   = arvalid_in && arready_out;
  assign rif.rd_addr = araddr_in;

  // Write path
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      addr_r   <= '0;
      data_r   <= '0;
      strb_r   <= '0;
      awready_out <= 1'b1;
      wready_out  <= 1'b1;
      bvalid_out  <= 1'b0;
      bresp_out   <= RESP_OKAY;
    end else if (ce_in) begin
      if (aw_hs) begin
        aw_got_r    <= 1'b1;
        addr_r      <= awaddr_in;
        awready_out <= 1'b0;
      end
      if (w_hs) begin
        w_got_r    <= 1'b1;
        data_r     <= wdata_in;
        strb_r     <= wstrb_in;
        wready_out <= 1'b0;
      end
      if (rif.wr_en) begin
        aw_got_r   <= 1'b0;
        w_got_r    <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out  <= rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_out && bready_in) begin
        bvalid_out  <= 1'b0;
        awready_out <= 1'b1;
        wready_out  <= 1'b1;
      end
    end
  end

  // Read path: one read in flight
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      arready_out <= 1'b1;
      rvalid_out  <= 1'b0;
      rdata_out   <= '0;
      rresp_out   <= RESP_OKAY;
    end else if (ce_in) begin
      if (rif.rd_en) begin
        arready_out <= 1'b0;
        rvalid_out  <= 1'b1;
        rdata_out   <= rif.rd_data;
        rresp_out   <= rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_out && rready_in) begin
        rvalid_out  <= 1'b0;
        arready_out <= 1'b1;
      end
    end
  end

endmodule // ttw_axil_slave

// File: rtl/ttw_desc_decode.sv
`timescale 1ns/1ps
module ttw_desc_decode
  import ttw_pkg::*;
(
  // Descriptor and address
  input  wire logic [31:0]  desc_in,
  input  wire logic [31:0]  va_in,
  // Classification
  output ttw_attr_s         attr_out,
  output logic              fault_out,
  output logic              rsvd_out,
  output logic              table_out,
  output logic              super_out,
  output logic [31:0]       pa_out,
  output logic [31:0]       l2_entry_out
);

  wire logic [1:0] dtype    = desc_in[1:0];
  wire logic       sect     = (dtype == DT_SECTION);
  wire logic [31:0] sect_pa = {desc_in[31:SECT_LSB], va_in[SECT_LSB-1:0]};
  wire logic [31:0] sup_pa  = {desc_in[31:SUPER_LSB], va_in[SUPER_LSB-1:0]};

  // Type 11 has no meaning here, so it aborts like a fault
  assign fault_out    = (dtype == DT_FAULT) || rsvd_out; // [R6] [R8]
  assign rsvd_out     = !sect && (dtype != DT_FAULT) && (dtype != DT_TABLE);
  assign table_out    = (dtype == DT_TABLE); // [R6] [R11]
  assign super_out    = sect && desc_in[SUPER_BIT]; // [R7]
  assign pa_out       = super_out ? sup_pa : sect_pa; // [R9] [R17]
  assign attr_out     = ttw_get_attr(desc_in); // [R15]
  // Second-level entry address: 1KB base plus eight VA bits
  assign l2_entry_out = {desc_in[31:L2_BASE_LSB], va_in[L2_IDX_LSB+L2_IDX_W-1:L2_IDX_LSB], 2'h0}; // [R16]

endmodule // ttw_desc_decode

// File: rtl/ttw_l1_walker.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] Disabled: physical address equals virtual, no fetch
// [R2] Untranslatable address aborts and reports cause
// [R3] Table is 4096 words, one per 1MB
// [R4] Software keeps table base 16KB aligned
// [R5] Fetch address is base plus four times VA[31:20]
// [R6] Low bits: 00 fault, 01 table, 10 section
// [R7] Bit 18 picks section or supersection
// [R8] Fault aborts: prefetch for fetch, else data
// [R9] Section address: descriptor top 12, VA low 20
// [R10] Sections finish without second-level access
// [R11] Table pointer hands base to second stage
// [R12] Software aligns supersections, writes sixteen copies
// [R13] Supersection flagged as one 16MB cache entry
// [R14] Fetches and data share one table
// [R15] Section returns permissions, cacheable, bufferable
// [R16] Second stage indexes with VA[19:12]
// [R17] Supersection address: descriptor top 8, VA low 24
// [R18] One aligned word read; requester stalls meanwhile
module ttw_l1_walker
  import ttw_pkg::*;
(
  // Clock, reset and enable
  input  wire logic              SYS_CLK_IN,
  input  wire logic              ARST_N_IN,
  input  wire logic              CLK_EN_IN,
  // AXI4-Lite register port
  input  wire logic [REG_AW-1:0] S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  input  wire logic [31:0]       S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  input  wire logic [REG_AW-1:0] S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  output logic [31:0]            S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN,
  // Core request
  input  wire logic              REQ_VALID_IN,
  input  wire logic [31:0]       REQ_VA_IN,
  input  wire logic              REQ_IS_FETCH_IN,
  output logic                   REQ_READY_OUT,
  // Core response
  output logic                   RSP_VALID_OUT,
  output logic [31:0]            RSP_PA_OUT,
  output ttw_attr_s              RSP_ATTR_OUT,
  output logic                   RSP_SUPER_OUT,
  output logic                   RSP_PREFETCH_ABORT_OUT,
  output logic                   RSP_DATA_ABORT_OUT,
  output logic [3:0]             RSP_FAULT_STATUS_OUT,
  // Second-level hand-off
  output logic                   L2_VALID_OUT,
  output logic [31:0]            L2_ENTRY_ADDR_OUT,
  output logic [31:0]            L2_VA_OUT,
  output logic                   L2_IS_FETCH_OUT,
  // Descriptor read port
  output logic                   MEM_RD_VALID_OUT,
  output logic [31:0]            MEM_RD_ADDR_OUT,
  input  wire logic              MEM_RD_READY_IN,
  input  wire logic              MEM_RD_DATA_VALID_IN,
  input  wire logic [31:0]       MEM_RD_DATA_IN,
  input  wire logic              MEM_RD_ERR_IN,
  // Interrupt
  output logic                   IRQ_OUT
);

  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA} ttw_state_e;

  ttw_reg_if rif ();

  ttw_state_e     state_r;
  logic [31:0]    ctrl_r;
  logic [31:0]    base_r;
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] mask_r;
  logic [31:0]    faddr_r;
  logic [3:0]     fstat_r;
  logic [31:0]    walks_r;
  logic [31:0]    va_r;
  logic           fetch_r;

  ttw_attr_s      dec_attr;
  logic           dec_fault;
  logic           dec_rsvd;
  logic           dec_table;
  logic           dec_super;
  logic [31:0]    dec_pa;
  logic [31:0]    dec_l2;

  // Byte-lane merge, shared by the control, base and mask words
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ttw_axil_slave u_bus (
    .clk_in      (SYS_CLK_IN),
    .arst_n_in   (ARST_N_IN),
    .ce_in       (CLK_EN_IN),
    .awaddr_in   (S_AXI_AWADDR_IN),
    .awvalid_in  (S_AXI_AWVALID_IN),
    .awready_out (S_AXI_AWREADY_OUT),
    .wdata_in    (S_AXI_WDATA_IN),
    .wstrb_in    (S_AXI_WSTRB_IN),
    .wvalid_in   (S_AXI_WVALID_IN),
    .wready_out  (S_AXI_WREADY_OUT),
    .bresp_out   (S_AXI_BRESP_OUT),
    .bvalid_out  (S_AXI_BVALID_OUT),
    .bready_in   (S_AXI_BREADY_IN),
    .araddr_in   (S_AXI_ARADDR_IN),
    .arvalid_in  (S_AXI_ARVALID_IN),
    .arready_out (S_AXI_ARREADY_OUT),
    .rdata_out   (S_AXI_RDATA_OUT),
    .rresp_out   (S_AXI_RRESP_OUT),
    .rvalid_out  (S_AXI_RVALID_OUT),
    .rready_in   (S_AXI_RREADY_IN),
    .rif         (rif.bus)
  );

  // The descriptor is decoded straight off the read data bus
  ttw_desc_decode u_dec (
    .desc_in      (MEM_RD_DATA_IN),
    .va_in        (va_r),
    .attr_out     (dec_attr),
    .fault_out    (dec_fault),
    .rsvd_out     (dec_rsvd),
    .table_out    (dec_table),
    .super_out    (dec_super),
    .pa_out       (dec_pa),
    .l2_entry_out (dec_l2)
  );

  // Register decode
  wire logic wr_ctrl   = rif.wr_en && (rif.wr_addr == OFS_CTRL);
  wire logic wr_base   = rif.wr_en && (rif.wr_addr == OFS_BASE);
  wire logic wr_status = rif.wr_en && (rif.wr_addr == OFS_STATUS);
  wire logic wr_mask   = rif.wr_en && (rif.wr_addr == OFS_MASK);
  assign rif.wr_ok = wr_ctrl || wr_base || wr_status || wr_mask;

  // Read mux; the read-only words answer OKAY, writes to them SLVERR
  always_comb begin
    rif.rd_ok   = 1'b1;
    rif.rd_data = '0;
    case (rif.rd_addr)
      OFS_CTRL:   rif.rd_data = ctrl_r;
      OFS_BASE:   rif.rd_data = base_r;
      OFS_STATUS: rif.rd_data = {{(32-ST_W){1'b0}}, status_r};
      OFS_MASK:   rif.rd_data = {{(32-ST_W){1'b0}}, mask_r};
      OFS_FADDR:  rif.rd_data = faddr_r;
      OFS_FSTAT:  rif.rd_data = {28'h0, fstat_r};
      OFS_WALKS:  rif.rd_data = walks_r;
      default:    rif.rd_ok   = 1'b0;
    endcase
  end

  // Walk events
  wire logic mmu_en   = ctrl_r[CTRL_EN_BIT];
  wire logic req_take = REQ_VALID_IN && REQ_READY_OUT;
  wire logic data_in  = (state_r == S_DATA) && MEM_RD_DATA_VALID_IN;
  wire logic ev_ext   = data_in && MEM_RD_ERR_IN;
  wire logic ev_fault = data_in && !MEM_RD_ERR_IN && dec_fault;
  wire logic ev_l2    = data_in && !MEM_RD_ERR_IN && dec_table;
  wire logic ev_sect  = data_in && !MEM_RD_ERR_IN && !dec_fault && !dec_table;
  wire logic ev_abort = ev_ext || ev_fault;
  // Base low bits are ignored in the fetch
  wire logic [31:0] tbl_base  = {base_r[31:BASE_LSB], {BASE_LSB{1'b0}}};
  wire logic [31:0] fetch_adr = tbl_base + {18'h0, REQ_VA_IN[L1_IDX_LSB +: L1_IDX_W], 2'h0}; // [R3] [R4] [R5]
  wire logic [3:0]  cause     = ev_ext ? FS_EXTERNAL : (dec_rsvd ? FS_RESERVED : FS_TRANSLATE);
  // Set wins over a write-one clear in the same cycle
  wire logic [ST_W-1:0] st_set = {ev_l2, ev_ext, ev_abort};
  wire logic [ST_W-1:0] st_clr = wr_status ? rif.wr_data[ST_W-1:0] & {ST_W{rif.wr_strb[0]}} : '0;
  wire logic [ST_W-1:0] status_nxt = (status_r & ~st_clr) | st_set;

  // Software registers and fault record
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctrl_r   <= CTRL_RST;
      base_r   <= BASE_RST;
      status_r <= STATUS_RST;
      mask_r   <= MASK_RST;
      faddr_r  <= '0;
      fstat_r  <= FS_NONE;
      walks_r  <= '0;
      IRQ_OUT  <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (wr_ctrl) ctrl_r <= merge(ctrl_r, rif.wr_data, rif.wr_strb) & 32'h0000_0001;
      if (wr_base) base_r <= merge(base_r, rif.wr_data, rif.wr_strb);
      if (wr_mask) mask_r <= ST_W'(merge({{(32-ST_W){1'b0}}, mask_r}, rif.wr_data, rif.wr_strb));
      status_r <= status_nxt;
      IRQ_OUT  <= |(status_nxt & mask_r);
      if (ev_abort) begin
        faddr_r <= va_r; // [R2]
        fstat_r <= cause; // [R2]
      end
      if (req_take && mmu_en) walks_r <= walks_r + 32'h1;
    end
  end

  // Walk sequencer: one descriptor read at a time, core stalled meanwhile
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_r  <= S_IDLE;
      va_r     <= '0;
      fetch_r  <= 1'b0;
      REQ_READY_OUT    <= 1'b1;
      MEM_RD_VALID_OUT <= 1'b0;
      MEM_RD_ADDR_OUT  <= '0;
    end else if (CLK_EN_IN) begin
      case (state_r)
        S_IDLE: begin
          if (req_take && mmu_en) begin
            va_r             <= REQ_VA_IN;
            fetch_r          <= REQ_IS_FETCH_IN;
            REQ_READY_OUT    <= 1'b0; // [R18]
            MEM_RD_VALID_OUT <= 1'b1; // [R18]
            MEM_RD_ADDR_OUT  <= fetch_adr; // [R5] [R14]
            state_r          <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (MEM_RD_READY_IN) begin
            MEM_RD_VALID_OUT <= 1'b0;
            state_r          <= S_DATA;
          end
        end
        S_DATA: begin
          if (MEM_RD_DATA_VALID_IN) begin
            REQ_READY_OUT <= 1'b1;
            state_r       <= S_IDLE;
          end
        end
        default: begin
          state_r       <= S_IDLE;
          REQ_READY_OUT <= 1'b1;
        end
      endcase
    end
  end

  // Core answer and second-level hand-off, one-cycle pulses
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RSP_VALID_OUT          <= 1'b0;
      RSP_PA_OUT             <= '0;
      RSP_ATTR_OUT           <= '0;
      RSP_SUPER_OUT          <= 1'b0;
      RSP_PREFETCH_ABORT_OUT <= 1'b0;
      RSP_DATA_ABORT_OUT     <= 1'b0;
      RSP_FAULT_STATUS_OUT   <= FS_NONE;
      L2_VALID_OUT           <= 1'b0;
      L2_ENTRY_ADDR_OUT      <= '0;
      L2_VA_OUT              <= '0;
      L2_IS_FETCH_OUT        <= 1'b0;
    end else if (CLK_EN_IN) begin
      RSP_VALID_OUT <= 1'b0;
      L2_VALID_OUT  <= 1'b0;
      if (req_take && !mmu_en) begin
        RSP_VALID_OUT          <= 1'b1; // [R1]
        RSP_PA_OUT             <= REQ_VA_IN; // [R1]
        RSP_ATTR_OUT           <= '0;
        RSP_SUPER_OUT          <= 1'b0;
        RSP_PREFETCH_ABORT_OUT <= 1'b0;
        RSP_DATA_ABORT_OUT     <= 1'b0;
        RSP_FAULT_STATUS_OUT   <= FS_NONE;
      end
      if (ev_abort) begin
        RSP_VALID_OUT          <= 1'b1;
        RSP_PA_OUT             <= '0;
        RSP_ATTR_OUT           <= '0;
        RSP_SUPER_OUT          <= 1'b0;
        RSP_PREFETCH_ABORT_OUT <= fetch_r; // [R8] [R2]
        RSP_DATA_ABORT_OUT     <= !fetch_r; // [R8] [R2]
        RSP_FAULT_STATUS_OUT   <= cause; // [R2]
      end
      if (ev_sect) begin
        RSP_VALID_OUT          <= 1'b1; // [R10]
        RSP_PA_OUT             <= dec_pa; // [R9] [R17]
        RSP_ATTR_OUT           <= dec_attr; // [R15] [R14]
        RSP_SUPER_OUT          <= dec_super; // [R13]
        RSP_PREFETCH_ABORT_OUT <= 1'b0;
        RSP_DATA_ABORT_OUT     <= 1'b0;
        RSP_FAULT_STATUS_OUT   <= FS_NONE;
      end
      if (ev_l2) begin
        L2_VALID_OUT      <= 1'b1; // [R11]
        L2_ENTRY_ADDR_OUT <= dec_l2; // [R11] [R16]
        L2_VA_OUT         <= va_r;
        L2_IS_FETCH_OUT   <= fetch_r;
      end
    end
  end

endmodule // ttw_l1_walker

// File: rtl/ttw_pkg.sv
package ttw_pkg;

  // Register offsets (byte addresses)
  localparam int unsigned REG_AW       = 8;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_BASE     = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_MASK     = 8'h0c;
  localparam logic [7:0]  OFS_FADDR    = 8'h10;
  localparam logic [7:0]  OFS_FSTAT    = 8'h14;
  localparam logic [7:0]  OFS_WALKS    = 8'h18;

  // Reset values
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] BASE_RST     = 32'h0000_0000;
  localparam logic [2:0]  STATUS_RST   = 3'h0;
  localparam logic [2:0]  MASK_RST     = 3'h0;

  // Control and status bit positions
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned ST_W         = 3;

  // Table geometry
  localparam int unsigned BASE_LSB     = 14;
  localparam int unsigned L1_IDX_LSB   = 20;
  localparam int unsigned L1_IDX_W     = 12;
  localparam int unsigned SECT_LSB     = 20;
  localparam int unsigned SUPER_LSB    = 24;
  localparam int unsigned SUPER_BIT    = 18;
  localparam int unsigned L2_BASE_LSB  = 10;
  localparam int unsigned L2_IDX_LSB   = 12;
  localparam int unsigned L2_IDX_W     = 8;

  // Descriptor type codes in bits [1:0]
  localparam logic [1:0]  DT_FAULT     = 2'h0;
  localparam logic [1:0]  DT_TABLE     = 2'h1;
  localparam logic [1:0]  DT_SECTION   = 2'h2;

  // Fault status codes
  localparam logic [3:0]  FS_NONE      = 4'h0;
  localparam logic [3:0]  FS_RESERVED  = 4'h1;
  localparam logic [3:0]  FS_TRANSLATE = 4'h5;
  localparam logic [3:0]  FS_EXTERNAL  = 4'h8;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Section attribute fields
  typedef struct packed {
    logic       non_global_bit;
    logic       shareable;
    logic       access_permission_extension;
    logic [2:0] type_extension_field;
    logic [1:0] access_permission_bits;
    logic [3:0] domain;
    logic       execute_never_bit;
    logic       cacheable;
    logic       bufferable;
  } ttw_attr_s;

  // Pull attribute fields out of a section descriptor
  function automatic ttw_attr_s ttw_get_attr(input logic [31:0] d);
    ttw_attr_s a;
    a = '{d[17], d[16], d[15], d[14:12], d[11:10], d[8:5], d[4], d[3], d[2]};
    return a;
  endfunction

endpackage

// File: rtl/ttw_reg_if.sv
`timescale 1ns/1ps
interface ttw_reg_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;

  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                input  wr_ok, rd_data, rd_ok);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface // ttw_reg_if
